// ===== hdl/can_bit_timing_and_acceptance_filter.sv
// CAN bit timing, resynchronisation and message buffer acceptance filter with AXI4-Lite access.
//
// Overview of operation
// - A bit spans 4 to 25 quanta; sample after segment one, transmit point at end.
// - Segment one length in quanta comes from a 4-bit timing field.
// - Segment two length in quanta comes from its own 4-bit timing field.
// - Each bit starts with a sync segment of exactly one quantum.
// - Falling edge on an idle bus hard-synchronises and restarts bit timing.
// - Soft resync only on recessive-to-dominant edges, limited to the jump width.
// - Phase error in module clocks: zero in sync, positive segment one, negative segment two.
// - Phase error within jump width realigns exactly like a hard sync.
// - Larger positive error lengthens segment one, larger negative shortens segment two.
// - Prescaler divides the module clock by the programmed value into quanta.
// - Bit rate equals clock over prescaler times one plus both segments.
// - Fifteen RAM buffers of eight 16-bit words, each receive or transmit.
// - A received frame goes only to the first matching receive buffer.
// - Writing the transmit-once status to a buffer schedules it for sending.
// - A remote frame schedules every matching answering buffer for transmission.
// - Shared mask serves buffers 0 to 13, basic mask serves buffer 14.
// - Mask bit one is don't-care; zero bits must equal the buffer identifier.
// - Buffers 0 to 13 scanned ascending before 14; 14 skipped if taken.
// - With lock enabled a buffer locks after one frame until read and rearmed.
// - With lock enabled and all matches locked, the frame is discarded.
// - Scan and copy happen only when the frame is valid at EOF bit six.
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "can_filter_regs.svh"
module can_bit_timing_and_acceptance_filter (
   input wire logic sys_clk, // System clock, 100 MHz.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic can_rx, // Receive line from the transceiver, 0 is dominant.
   input wire logic bus_idle, // High while the protocol engine sees an idle bus.
   input wire logic frame_valid, // Pulse at the sixth EOF bit of a valid frame.
   input wire logic [31:0] frame_id, // Identifier of the frame in the hidden buffer.
   input wire logic frame_remote, // The held frame is a remote frame.
   input wire logic [3:0] frame_dlc, // Data length code of the held frame.
   input wire logic [63:0] frame_data, // Data bytes of the held frame, first byte on top.
   output logic sample_pulse, // One-cycle pulse at the sample point.
   output logic tx_point_pulse, // One-cycle pulse at the transmit point.
   output logic sampled_bit, // Bus level taken at the last sample point.
   output logic [14:0] tx_request, // Buffers scheduled for transmission.
   output logic frame_stored, // Pulse: the held frame was copied to a buffer.
   output logic frame_dropped, // Pulse: the held frame found no buffer.
   input wire logic [11:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [11:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready // Read data ready.
);

   can_filter_pkg::can_state_t r;
   can_filter_pkg::can_state_t n;

   logic [5:0] psc_v;
   logic [4:0] t1e;
   logic [4:0] t2e;
   logic [4:0] sjw_q;
   logic [4:0] sample_q;
   logic [4:0] end_q;
   logic tick;
   logic fall;
   logic [10:0] sjw_clk;
   logic [10:0] len_clk;
   logic [10:0] err_pos;
   logic [10:0] err_neg;
   logic [14:0] rx_cfg;
   logic [14:0] ans_cfg;
   logic [14:0] id_match;
   logic [14:0] rx_hit;
   logic [14:0] first_sel;
   logic found;
   logic wr_fire;
   logic [11:0] wa;
   logic [11:0] woff;
   logic [11:0] roff;
   logic w_ram;
   logic r_ram;
   logic [3:0] wbuf;
   logic [3:0] st_new;

   // Byte-strobe merge of a bus write into a stored word.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] s);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Effective segment lengths, clamped so a bit stays within 4 to 25 quanta.
   always_comb begin
      psc_v = (r.timing[`PSC_MSB:`PSC_LSB] == 6'h00) ? 6'h01 : r.timing[`PSC_MSB:`PSC_LSB];
      t1e = {1'b0, r.timing[`TIME_SEG_BEFORE_SAMPLE_MSB:`TIME_SEG_BEFORE_SAMPLE_LSB]};
      t2e = {1'b0, r.timing[`TIME_SEG_AFTER_SAMPLE_MSB:`TIME_SEG_AFTER_SAMPLE_LSB]};
      if (t1e < `MIN_TIME_SEG_BEFORE_SAMPLE) begin
         t1e = `MIN_TIME_SEG_BEFORE_SAMPLE;
      end
      if (t2e < `MIN_TIME_SEG_AFTER_SAMPLE) begin
         t2e = `MIN_TIME_SEG_AFTER_SAMPLE;
      end
      if (5'(t1e + t2e) > 5'(`MAX_TQ - 5'h01)) begin
         t2e = 5'(`MAX_TQ - 5'h01 - t1e);
      end
      sjw_q = {3'h0, r.timing[`SJW_MSB:`SJW_LSB]};
      sample_q = 5'(t1e + r.ext);
      end_q = 5'(t1e + r.ext + t2e - r.cut);
      sjw_clk = 11'(sjw_q * psc_v);
      len_clk = 11'((end_q + 5'h01) * psc_v);
      err_pos = 11'(r.bit_clk - {5'h00, psc_v});
      err_neg = 11'(len_clk - r.bit_clk);
   end

   assign tick = (r.pc == 6'(psc_v - 6'h01));
   assign fall = r.rx_prev & ~can_rx;

   // Per-buffer configuration and identifier match under the proper mask.
   genvar gi;
   generate
      for (gi = 0; gi < 15; gi++) begin : g_buf
         logic [3:0] st;
         logic [31:0] bid;
         logic [31:0] msk;
         assign st = r.ram[gi*8 + 7][3:0];
         assign bid = {r.ram[gi*8], r.ram[gi*8 + 1]};
         assign msk = (gi == 14) ? r.mask_basic : r.mask_shared;
         assign rx_cfg[gi] = (st == `ST_RX_READY) | (st == `ST_RX_FULL) |
                             (st == `ST_RX_OVERRUN);
         assign ans_cfg[gi] = (st == `ST_TX_ANSWER);
         assign id_match[gi] = ((frame_id ^ bid) & ~msk) == 32'h0000_0000;
         assign rx_hit[gi] = rx_cfg[gi] & id_match[gi] & ~(r.lock_en & r.locked[gi]);
      end
   endgenerate

   // First-match scan, ascending with buffer 14 last.
   always_comb begin
      first_sel = 15'h0000;
      found = 1'b0;
      for (int i = 0; i < 15; i++) begin
         if (rx_hit[i] && !found) begin
            first_sel[i] = 1'b1;
            found = 1'b1;
         end
      end
   end

   // Address decode for the pending write and the incoming read.
   assign wr_fire = r.aw_have & r.w_have & ~r.bvalid;
   assign wa = r.awaddr;
   assign woff = 12'(wa - `OFF_RAM_BASE);
   assign roff = 12'(s_axi_araddr - `OFF_RAM_BASE);
   assign w_ram = (wa[11:9] == 3'h1) && (woff[8:2] < `RAM_WORDS);
   assign r_ram = (s_axi_araddr[11:9] == 3'h1) && (roff[8:2] < `RAM_WORDS);
   assign wbuf = woff[8:5];
   assign st_new = r.wdata[3:0];

   // Next state: bit timing, register bus, then frame copy.
   always_comb begin
      n = r;
      n.sample_pulse = 1'b0;
      n.tx_point = 1'b0;
      n.stored = 1'b0;
      n.dropped = 1'b0;
      n.rx_prev = can_rx;
      // Quantum and bit counters; sync segment is quantum 0.
      n.bit_clk = 11'(r.bit_clk + 11'h001);
      n.pc = tick ? 6'h00 : 6'(r.pc + 6'h01);
      if (tick) begin
         n.q = 5'(r.q + 5'h01);
         if (r.q == sample_q) begin
            n.sample_pulse = 1'b1;
            n.sampled_bit = can_rx;
         end
         if (r.q >= end_q) begin
            n.q = 5'h00;
            n.bit_clk = 11'h000;
            n.ext = 5'h00;
            n.cut = 5'h00;
            n.resynced = 1'b0;
            n.tx_point = 1'b1;
         end
      end
      if (fall && bus_idle) begin
         n.q = 5'h00;
         n.pc = 6'h00;
         n.bit_clk = 11'h000;
         n.ext = 5'h00;
         n.cut = 5'h00;
         n.resynced = 1'b0;
      end else if (fall && !r.resynced) begin
         n.resynced = 1'b1;
         if (r.q == 5'h00 ||
             (r.q <= sample_q && err_pos <= sjw_clk) ||
             (r.q > sample_q && err_neg <= sjw_clk)) begin
            n.q = 5'h00;
            n.pc = 6'h00;
            n.bit_clk = 11'h000;
            n.ext = 5'h00;
            n.cut = 5'h00;
            n.resynced = 1'b0;
         end else if (r.q <= sample_q) begin
            n.ext = sjw_q;
         end else begin
            n.cut = sjw_q;
         end
      end
      // Write channel: address and data are taken independently.
      if (s_axi_awvalid && r.awready) begin
         n.aw_have = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         n.w_have = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (wr_fire) begin
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `RESP_OKAY;
         case (wa)
            `OFF_BIT_TIMING: n.timing = merge(r.timing, r.wdata, r.wstrb);
            `OFF_SHARED_MASK: n.mask_shared = merge(r.mask_shared, r.wdata, r.wstrb);
            `OFF_BASIC_MASK: n.mask_basic = merge(r.mask_basic, r.wdata, r.wstrb);
            `OFF_CONFIG: begin
               if (r.wstrb[0]) begin
                  n.lock_en = r.wdata[`LOCK_EN_BIT];
               end
            end
            `OFF_TX_REQUEST: n.tx_req = r.tx_req & ~r.wdata[14:0];
            `OFF_LOCKED: n.bresp = `RESP_OKAY;
            default: begin
               if (w_ram) begin
                  n.ram[woff[8:2]] = 16'(merge({16'h0000, r.ram[woff[8:2]]}, r.wdata,
                                               r.wstrb));
                  if (woff[4:2] == `WORD_STATUS && r.wstrb[0]) begin
                     if (st_new == `ST_TX_ONCE) begin
                        n.tx_req[wbuf] = 1'b1;
                     end
                     if (st_new == `ST_RX_READY && r.was_read[wbuf]) begin
                        n.locked[wbuf] = 1'b0;
                        n.was_read[wbuf] = 1'b0;
                     end
                  end
               end else begin
                  n.bresp = `RESP_SLVERR;
               end
            end
         endcase
      end
      // Read channel: answer one cycle after the address is taken.
      if (r.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r.arready) begin
         n.rvalid = 1'b1;
         n.rresp = `RESP_OKAY;
         case (s_axi_araddr)
            `OFF_BIT_TIMING: n.rdata = r.timing;
            `OFF_SHARED_MASK: n.rdata = r.mask_shared;
            `OFF_BASIC_MASK: n.rdata = r.mask_basic;
            `OFF_CONFIG: n.rdata = {31'h0, r.lock_en};
            `OFF_TX_REQUEST: n.rdata = {17'h0, r.tx_req};
            `OFF_LOCKED: n.rdata = {17'h0, r.locked};
            default: begin
               if (r_ram) begin
                  n.rdata = {16'h0000, r.ram[roff[8:2]]};
                  if (roff[4:2] != `WORD_STATUS && r.locked[roff[8:5]]) begin
                     n.was_read[roff[8:5]] = 1'b1;
                  end
               end else begin
                  n.rdata = 32'h0000_0000;
                  n.rresp = `RESP_SLVERR;
               end
            end
         endcase
      end
      // Copy of the validated frame; it overrides a bus write in the same cycle.
      if (frame_valid) begin
         n.stored = found;
         n.dropped = ~found;
         for (int i = 0; i < 15; i++) begin
            if (first_sel[i]) begin
               n.ram[i*8] = frame_id[31:16];
               n.ram[i*8 + 1] = frame_id[15:0];
               n.ram[i*8 + 2] = frame_data[63:48];
               n.ram[i*8 + 3] = frame_data[47:32];
               n.ram[i*8 + 4] = frame_data[31:16];
               n.ram[i*8 + 5] = frame_data[15:0];
               n.ram[i*8 + 6] = {11'h000, frame_remote, frame_dlc};
               n.ram[i*8 + 7] = {12'h000, (r.ram[i*8 + 7][3:0] == `ST_RX_READY) ?
                                 `ST_RX_FULL : `ST_RX_OVERRUN};
               n.locked[i] = r.lock_en;
               n.was_read[i] = 1'b0;
            end
            if (frame_remote && ans_cfg[i] && id_match[i]) begin
               n.tx_req[i] = 1'b1;
            end
         end
      end
      n.awready = ~n.aw_have & ~n.bvalid;
      n.wready = ~n.w_have & ~n.bvalid;
      n.arready = ~n.rvalid;
   end

   // State register with synchronous reset.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r <= '0;
         r.timing <= `RST_BIT_TIMING;
         r.mask_shared <= `RST_MASK;
         r.mask_basic <= `RST_MASK;
         r.rx_prev <= 1'b1;
         r.sampled_bit <= 1'b1;
         r.awready <= 1'b1;
         r.wready <= 1'b1;
         r.arready <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // Outputs come straight from the state register.
   assign sample_pulse = r.sample_pulse;
   assign tx_point_pulse = r.tx_point;
   assign sampled_bit = r.sampled_bit;
   assign tx_request = r.tx_req;
   assign frame_stored = r.stored;
   assign frame_dropped = r.dropped;
   assign s_axi_awready = r.awready;
   assign s_axi_wready = r.wready;
   assign s_axi_bresp = r.bresp;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_arready = r.arready;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign s_axi_rvalid = r.rvalid;

   // Checks on timing and acceptance behaviour.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   hard_sync_a: assert property (fall && bus_idle |=> r.q == 5'h00 && r.bit_clk == 11'h000)
      else $error("Hard sync did not restart bit timing.");
   bit_restart_a: assert property (r.tx_point |-> r.q == 5'h00 && r.ext == 5'h00)
      else $error("Transmit point not at start of a fresh bit.");
   bit_len_a: assert property (r.q <= 5'h1b)
      else $error("Bit exceeds the quantum limit.");
   ext_bound_a: assert property (r.ext <= sjw_q && r.cut <= sjw_q)
      else $error("Resync adjustment exceeds jump width.");
   store_first_a: assert property (frame_valid && found |=> frame_stored && !frame_dropped)
      else $error("Matched frame was not stored.");
   drop_frame_a: assert property (frame_valid && !found |=> frame_dropped)
      else $error("Unmatched frame was not dropped.");
   single_buf_a: assert property (frame_valid |-> $onehot0(first_sel))
      else $error("Frame copied to more than one buffer.");
   basic_skip_a: assert property (frame_valid && |rx_hit[13:0] |-> !first_sel[14])
      else $error("Buffer 14 taken although a lower buffer matched.");
   lock_set_a: assert property (frame_valid && r.lock_en
                                |=> &(r.locked | ~$past(first_sel)))
      else $error("Receive buffer did not lock.");
   answer_a: assert property (frame_valid && frame_remote
                              |=> &(tx_request | ~$past(ans_cfg & id_match)))
      else $error("Answer buffer not scheduled.");

   hard_sync_c: cover property (fall && bus_idle);
   extend_c: cover property (r.ext != 5'h00 ##[1:200] r.tx_point);
   store_c: cover property (frame_stored);
   drop_locked_c: cover property (frame_valid && r.lock_en && !found && |(id_match & rx_cfg));

endmodule
`default_nettype wire

// ===== hdl/can_filter_regs.svh
// Register offsets, field positions, reset values and code points of the CAN timing and filter.
`ifndef CAN_FILTER_REGS_SVH
`define CAN_FILTER_REGS_SVH
// Register byte offsets on the 12-bit register bus.
`define OFF_BIT_TIMING 12'h000
`define OFF_SHARED_MASK 12'h004
`define OFF_BASIC_MASK 12'h008
`define OFF_CONFIG 12'h00c
`define OFF_TX_REQUEST 12'h010
`define OFF_LOCKED 12'h014
`define OFF_RAM_BASE 12'h200
`define RAM_WORDS 7'h78
// Field positions inside bit_timing_register.
`define PSC_LSB 0
`define PSC_MSB 5
`define TIME_SEG_BEFORE_SAMPLE_LSB 8
`define TIME_SEG_BEFORE_SAMPLE_MSB 11
`define TIME_SEG_AFTER_SAMPLE_LSB 12
`define TIME_SEG_AFTER_SAMPLE_MSB 15
`define SJW_LSB 16
`define SJW_MSB 17
// Position of rx_buffer_lock_enable in the configuration register.
`define LOCK_EN_BIT 0
// Reset values.
`define RST_BIT_TIMING 32'h0001_3401
`define RST_MASK 32'h0000_0000
// Buffer word layout and status codes.
`define WORD_ID_HI 3'h0
`define WORD_ID_LO 3'h1
`define WORD_CTRL 3'h6
`define WORD_STATUS 3'h7
`define ST_RX_NOT_ACTIVE 4'h0
`define ST_RX_READY 4'h2
`define ST_RX_FULL 4'h4
`define ST_RX_OVERRUN 4'h6
`define ST_TX_NOT_ACTIVE 4'h8
`define ST_TX_ANSWER 4'ha
`define ST_TX_ONCE 4'hc
// Bit time limits in time quanta.
`define MIN_TIME_SEG_BEFORE_SAMPLE 5'h02
`define MIN_TIME_SEG_AFTER_SAMPLE 5'h01
`define MAX_TQ 5'h19
// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== hdl/can_filter_pkg.sv
// Types shared by the CAN bit timing and acceptance filter.
`include "can_filter_regs.svh"
package can_filter_pkg;
   // Complete state of the block, registered in one process.
   typedef struct packed {
      logic [119:0][15:0] ram;
      logic [31:0] timing;
      logic [31:0] mask_shared;
      logic [31:0] mask_basic;
      logic lock_en;
      logic [14:0] locked;
      logic [14:0] was_read;
      logic [14:0] tx_req;
      logic rx_prev;
      logic resynced;
      logic [5:0] pc;
      logic [4:0] q;
      logic [10:0] bit_clk;
      logic [4:0] ext;
      logic [4:0] cut;
      logic sample_pulse;
      logic tx_point;
      logic sampled_bit;
      logic stored;
      logic dropped;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic aw_have;
      logic w_have;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } can_state_t;
endpackage

// ===== sim/can_node_model.sv
// Behavioural CAN node: drives the receive line and hands over validated frames.
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
   input wire logic sys_clk, // System clock.
   output var logic can_rx, // Bus level, 1 is recessive.
   output var logic bus_idle, // High while no frame is on the bus.
   output var logic frame_valid, // Pulse at the sixth end-of-frame bit.
   output var logic [31:0] frame_id, // Identifier of the held frame.
   output var logic frame_remote, // Held frame is a remote frame.
   output var logic [3:0] frame_dlc, // Data length code.
   output var logic [63:0] frame_data // Data bytes.
);
   // The bus rests recessive and idle; frame fields start scrambled.
   initial begin
      can_rx = 1'b1;
      bus_idle = 1'b1;
      frame_valid = 1'b0;
      frame_id = 32'ha5a5_5a5a;
      frame_remote = 1'b1;
      frame_dlc = 4'h5;
      frame_data = 64'h5a5a_a5a5_5a5a_a5a5;
   end
   // Makes a falling edge, either on an idle bus or inside a running frame.
   task automatic start_frame(input logic idle);
      @(posedge sys_clk);
      can_rx <= 1'b0;
      bus_idle <= idle;
   endtask
   // Returns the bus to recessive and idle.
   task automatic end_frame();
      @(posedge sys_clk);
      can_rx <= 1'b1;
      bus_idle <= 1'b1;
   endtask
   // Offers a validated frame for one cycle, then scrambles the held identifier, remote flag and data.
   task automatic deliver(input logic [31:0] id, input logic remote);
      @(posedge sys_clk);
      frame_valid <= 1'b1;
      frame_id <= id;
      frame_remote <= remote;
      frame_dlc <= 4'h8;
      frame_data <= {id, ~id};
      @(posedge sys_clk);
      frame_valid <= 1'b0;
      frame_id <= ~id;
      frame_remote <= ~remote;
      frame_data <= {~id, id};
   endtask
endmodule
`default_nettype wire

// ===== sim/can_bit_timing_and_acceptance_filter_tb.sv
// Self-checking bench for the CAN bit timing and acceptance filter.
`timescale 1ns/1ps
`default_nettype none
`include "can_filter_regs.svh"
module can_bit_timing_and_acceptance_filter_tb;
   logic sys_clk, rst, can_rx, bus_idle, frame_valid, frame_remote;
   logic [31:0] frame_id, s_axi_wdata, s_axi_rdata, rd_word;
   logic [3:0] frame_dlc, s_axi_wstrb;
   logic [63:0] frame_data;
   logic sample_pulse, tx_point_pulse, sampled_bit, frame_stored, frame_dropped;
   logic [14:0] tx_request;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int fail_count = 0;
   int n_compared = 0;
   int per, smp, n;

   can_node_model node (.sys_clk(sys_clk), .can_rx(can_rx), .bus_idle(bus_idle),
      .frame_valid(frame_valid), .frame_id(frame_id), .frame_remote(frame_remote),
      .frame_dlc(frame_dlc), .frame_data(frame_data));

   can_bit_timing_and_acceptance_filter dut (.sys_clk(sys_clk), .rst(rst), .can_rx(can_rx),
      .bus_idle(bus_idle), .frame_valid(frame_valid), .frame_id(frame_id),
      .frame_remote(frame_remote), .frame_dlc(frame_dlc), .frame_data(frame_data),
      .sample_pulse(sample_pulse), .tx_point_pulse(tx_point_pulse), .sampled_bit(sampled_bit),
      .tx_request(tx_request), .frame_stored(frame_stored), .frame_dropped(frame_dropped),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   // Clock at 100 MHz.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Compares a seen value with the expected one and counts the result.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t %s: saw %h, expected %h", $time, what, seen, exp);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("Compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Byte address of word w of message buffer b.
   function automatic logic [11:0] ba(input int b, input int w);
      return 12'h200 + 12'(b * 32 + w * 4);
   endfunction

   // Register write; address and data offered together, each released when taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask

   // Register read; data and response taken at the edge where rvalid is seen.
   task automatic rd(input logic [11:0] a);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) begin
            rd_word = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask

   // Reads a word and compares the masked value and the response code.
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] r);
      rd(a);
      check(rd_word & ((a >= 12'h200) ? 32'h0000_ffff : 32'hffff_ffff), exp, "read data");
      check(resp, r, "read response");
   endtask

   // Loads the identifier and status of one buffer.
   task automatic setbuf(input int b, input logic [31:0] id, input logic [3:0] st);
      wr(ba(b, 0), {16'h0000, id[31:16]});
      wr(ba(b, 1), {16'h0000, id[15:0]});
      wr(ba(b, 7), {28'h0000000, st});
   endtask

   // Delivers a frame and compares the stored and dropped pulses.
   task automatic frame(input logic [31:0] id, input logic rem, input logic st, input logic dr);
      node.deliver(id, rem);
      #1;
      check(frame_stored, st, "stored pulse");
      check(frame_dropped, dr, "dropped pulse");
   endtask

   // Counts clocks between two transmit points and from the sample point.
   task automatic measure();
      n = 0;
      per = 0;
      smp = 0;
      do begin @(posedge sys_clk); n++; end while (tx_point_pulse !== 1'b1 && n < 200);
      do begin
         @(posedge sys_clk);
         per++;
         if (sample_pulse === 1'b1) smp = per;
      end while (tx_point_pulse !== 1'b1 && per < 200);
   endtask

   // Watchdog for a hung handshake.
   initial begin
      #300us;
      fail_count++;
      close_out();
   end

   // Test sequence.
   initial begin
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      rdchk(`OFF_BIT_TIMING, 32'h0001_3401, `RESP_OKAY);
      rdchk(12'h018, 32'h0, `RESP_SLVERR);
      wr(12'h018, 32'h1234_5678);
      check(resp, `RESP_SLVERR, "unmapped write");
      $display("Test registers done");
      wr(`OFF_BIT_TIMING, 32'h0001_4502);
      measure();
      check(per, 20, "bit period");
      check(per - smp, 8, "sample to transmit point");
      node.start_frame(1'b1);
      n = 0;
      while (sample_pulse !== 1'b1 && n < 100) begin @(posedge sys_clk); n++; end
      check(n >= 12 && n <= 16, 1, "hard sync to sample");
      check(sampled_bit, 0, "sampled level");
      node.end_frame();
      // Edge three clocks into segment one: one jump width added before the sample.
      measure();
      repeat (3) @(posedge sys_clk);
      node.start_frame(1'b0);
      n = 0;
      while (sample_pulse !== 1'b1 && n < 100) begin @(posedge sys_clk); n++; end
      check(n, 10, "resync in segment one");
      node.end_frame();
      $display("Test bit timing done");
      wr(`OFF_SHARED_MASK, 32'h0000_000f);
      wr(`OFF_BASIC_MASK, 32'h0000_ffff);
      setbuf(3, 32'h0123_4560, `ST_RX_READY);
      setbuf(5, 32'h0123_4560, `ST_RX_READY);
      setbuf(14, 32'h0abc_0000, `ST_RX_READY);
      frame(32'h0123_4567, 1'b0, 1'b1, 1'b0);
      rdchk(ba(3, 7), `ST_RX_FULL, `RESP_OKAY);
      rdchk(ba(5, 7), `ST_RX_READY, `RESP_OKAY);
      rdchk(ba(3, 1), 32'h0000_4567, `RESP_OKAY);
      frame(32'h0abc_1234, 1'b0, 1'b1, 1'b0);
      rdchk(ba(14, 7), `ST_RX_FULL, `RESP_OKAY);
      frame(32'h0123_4577, 1'b0, 1'b0, 1'b1);
      $display("Test acceptance done");
      wr(`OFF_CONFIG, 32'h0000_0001);
      frame(32'h0123_4561, 1'b0, 1'b1, 1'b0);
      rdchk(ba(3, 7), `ST_RX_OVERRUN, `RESP_OKAY);
      frame(32'h0123_4562, 1'b0, 1'b1, 1'b0);
      rdchk(ba(5, 7), `ST_RX_FULL, `RESP_OKAY);
      frame(32'h0123_4563, 1'b0, 1'b0, 1'b1);
      rdchk(`OFF_LOCKED, 32'h0000_0028, `RESP_OKAY);
      rdchk(ba(3, 0), 32'h0000_0123, `RESP_OKAY);
      wr(ba(3, 7), {28'h0, `ST_RX_READY});
      rdchk(`OFF_LOCKED, 32'h0000_0020, `RESP_OKAY);
      $display("Test buffer lock done");
      setbuf(7, 32'h0555_0000, `ST_TX_ANSWER);
      setbuf(8, 32'h0555_0001, `ST_TX_ANSWER);
      frame(32'h0555_0002, 1'b1, 1'b0, 1'b1);
      check(tx_request, 15'h0180, "remote answer");
      wr(ba(9, 7), {28'h0, `ST_TX_ONCE});
      check(tx_request, 15'h0380, "software send");
      wr(`OFF_TX_REQUEST, 32'h0000_0380);
      check(tx_request, 15'h0000, "request cleared");
      $display("Test transmit requests done");
      close_out();
   end
endmodule
`default_nettype wire
